/* isv_cpu_model.sv */
// isv_cpu_model: core that acknowledges each presented request
// assumes: ack_wait+1 cycles of delay, ack is a one-cycle pulse
`timescale 1ns/1ps
module isv_cpu_model
  import isv_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cpu_req,
  input  wire logic [3:0] ack_wait,
  output logic            cpu_ack
);
  logic [3:0] cnt;
  always_ff @(posedge clk) begin
    if (rst || !cpu_req || cpu_ack) begin
      cnt     <= 4'h0;
      cpu_ack <= 1'b0;
    end else if (cnt == ack_wait) begin
      cpu_ack <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : isv_cpu_model

/* isv_pkg.sv */
// isv_pkg: codes, handler addresses and priorities of the interrupt sources
// assumes: exception codes are 16 bits, handler addresses 32 bits
package isv_pkg;
  localparam int unsigned ISV_NUM_MASKABLE = 18;
  localparam int unsigned ISV_PRIO_W       = 5;
  localparam logic [15:0] ISV_CODE_RESET   = 16'h0000;
  localparam logic [15:0] ISV_CODE_NMI     = 16'h0010;
  localparam logic [15:0] ISV_CODE_TRAP_A  = 16'h0040;
  localparam logic [15:0] ISV_CODE_TRAP_B  = 16'h0050;
  localparam logic [15:0] ISV_CODE_ILLEGAL = 16'h0060;
  localparam logic [15:0] ISV_CODE_MASK0   = 16'h0080;
  localparam logic [15:0] ISV_CODE_STEP    = 16'h0010;
  localparam logic [15:0] ISV_CODE_TIMER_A = 16'h0120;
  // priorities 8 and above skip two unused vector slots
  localparam logic [4:0]  ISV_PRIO_GAP     = 5'h08;
  localparam logic [15:0] ISV_GAP_SLOTS    = 16'h0002;
  localparam logic [3:0]  ISV_NIBBLE_MASK  = 4'hf;
  typedef enum logic [2:0] {
    ISV_KIND_NONE,
    ISV_KIND_RESET,
    ISV_KIND_NMI,
    ISV_KIND_TRAP,
    ISV_KIND_MASKABLE
  } isv_kind_e;
endpackage : isv_pkg

/* isv_sync.sv */
// isv_sync: two-flop synchroniser with rising-edge pulse after the second flop
// assumes: d comes from outside the clk domain
`timescale 1ns/1ps
module isv_sync
  import isv_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      level,
  output logic      rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } isv_sync_s;
  isv_sync_s r;
  isv_sync_s next_r;

  always_comb begin
    next_r    = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign level = r.s2;
  assign rise  = r.s2 & ~r.s3;
endmodule : isv_sync

/* isv_vectoring.sv */
// isv_vectoring: latches interrupt sources and presents one vector to the cpu
// assumes: cpu takes a request with cpu_ack; trap inputs are same-clock pulses
// Overview of operation
// - seven pin edge requests, maskable, priorities 0-6, codes 0080h-00e0h
// - illegal opcode or debug trap gives code 0060h, return to next instr
// - trap groups give 004nh and 005nh, one handler per group
// - timer a overflow at priority 8, matches 9-12, codes 0120h-0160h
// - in six-phase pwm mode timer b overflow is the valley from option logic
// - in six-phase pwm mode timer b match 0 is the crest from option logic
// - low voltage raises interrupt when detector enabled and set to interrupt
`timescale 1ns/1ps
module isv_vectoring
  import isv_pkg::*;
#(
  parameter int unsigned NUM_PINS = 7
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [NUM_PINS-1:0]         ext_pin_irq,
  input  wire logic                        watchdog_nmi,
  input  wire logic                        lowvolt_enable,
  input  wire logic                        lowvolt_action_select,
  input  wire logic                        low_voltage_detector,
  input  wire logic                        timer_a_overflow_irq,
  input  wire logic [3:0]                  timer_a_match_irq,
  input  wire logic                        timer_b_six_phase,
  input  wire logic                        timer_b_overflow_irq,
  input  wire logic                        timer_b_valley_irq,
  input  wire logic                        timer_b_match0_irq,
  input  wire logic                        timer_b_crest_irq,
  input  wire logic [2:0]                  timer_b_match_irq,
  input  wire logic                        soft_trap_group_a,
  input  wire logic                        soft_trap_group_b,
  input  wire logic [3:0]                  trap_operand,
  input  wire logic                        illegal_opcode_trap,
  input  wire logic                        debug_trap,
  input  wire logic [31:0]                 following_instr_address,
  input  wire logic [ISV_NUM_MASKABLE-1:0] irq_mask,
  input  wire logic                        cpu_ack,
  output logic                             cpu_req,
  output isv_kind_e                        cpu_kind,
  output logic [15:0]                      cpu_code,
  output logic [31:0]                      cpu_handler,
  output logic [31:0]                      cpu_return_pc,
  output logic [ISV_PRIO_W-1:0]            cpu_prio,
  output logic [ISV_NUM_MASKABLE-1:0]      irq_pending
);
  typedef struct packed {
    logic [ISV_NUM_MASKABLE-1:0] pend;
    logic                        nmi_pend;
    logic                        req;
    isv_kind_e                   kind;
    logic [15:0]                 code;
    logic [31:0]                 handler;
    logic [31:0]                 ret_pc;
    logic [ISV_PRIO_W-1:0]       prio;
  } isv_state_s;

  isv_state_s r;
  isv_state_s next_r;

  logic [NUM_PINS-1:0]         pin_rise;
  logic                        wdt_rise;
  logic                        lvd_rise;
  logic [ISV_NUM_MASKABLE-1:0] raw_event;

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    isv_sync u_pin (
      .clk   (clk),
      .rst   (rst),
      .d     (ext_pin_irq[i]),
      .level (),
      .rise  (pin_rise[i])
    );
  end

  isv_sync u_wdt (
    .clk   (clk),
    .rst   (rst),
    .d     (watchdog_nmi),
    .level (),
    .rise  (wdt_rise)
  );

  isv_sync u_lvd (
    .clk   (clk),
    .rst   (rst),
    .d     (low_voltage_detector),
    .level (),
    .rise  (lvd_rise)
  );

  // maskable event vector indexed by default priority
  always_comb begin
    raw_event                  = '0;
    raw_event[NUM_PINS-1:0]    = pin_rise;
    // interrupt request only when detection selects interrupt, not reset
    raw_event[7]  = lvd_rise & lowvolt_enable & ~lowvolt_action_select;
    raw_event[8]  = timer_a_overflow_irq;
    raw_event[12:9] = timer_a_match_irq;
    raw_event[13] = timer_b_six_phase ? timer_b_valley_irq
                                      : timer_b_overflow_irq;
    raw_event[14] = timer_b_six_phase ? timer_b_crest_irq
                                      : timer_b_match0_irq;
    raw_event[17:15] = timer_b_match_irq;
  end

  // code of a maskable source from its priority
  function automatic logic [15:0] mask_code(input logic [ISV_PRIO_W-1:0] p);
    logic [15:0] slot;
    slot = {11'h000, p};
    if (p >= ISV_PRIO_GAP) begin
      slot = slot + ISV_GAP_SLOTS;
    end
    mask_code = 16'(ISV_CODE_MASK0 + 16'(slot * ISV_CODE_STEP));
  endfunction : mask_code

  always_comb begin
    logic                  found;
    logic [ISV_PRIO_W-1:0] win;
    next_r = r;
    found  = 1'b0;
    win    = '0;
    // set wins over the clear done on acceptance below
    if (cpu_ack && r.req && r.kind == ISV_KIND_MASKABLE) begin
      next_r.pend[r.prio] = 1'b0;
    end
    if (cpu_ack && r.req && r.kind == ISV_KIND_NMI) begin
      next_r.nmi_pend = 1'b0;
    end
    next_r.pend = next_r.pend | raw_event;
    if (wdt_rise) begin
      next_r.nmi_pend = 1'b1;
    end
    if (cpu_ack && r.req) begin
      next_r.req  = 1'b0;
      next_r.kind = ISV_KIND_NONE;
    end
    // smallest unmasked priority wins
    for (int i = ISV_NUM_MASKABLE - 1; i >= 0; i--) begin
      if (r.pend[i] && !irq_mask[i]) begin
        found = 1'b1;
        win   = ISV_PRIO_W'(i);
      end
    end
    if (!r.req || cpu_ack) begin
      next_r.ret_pc = following_instr_address;
      if (illegal_opcode_trap || debug_trap) begin
        next_r.req     = 1'b1;
        next_r.kind    = ISV_KIND_TRAP;
        next_r.code    = ISV_CODE_ILLEGAL;
        next_r.handler = {16'h0000, ISV_CODE_ILLEGAL};
        next_r.prio    = '0;
      end else if (soft_trap_group_a || soft_trap_group_b) begin
        next_r.req     = 1'b1;
        next_r.kind    = ISV_KIND_TRAP;
        next_r.code    = (soft_trap_group_a ? ISV_CODE_TRAP_A
                                            : ISV_CODE_TRAP_B)
                         | {12'h000, trap_operand & ISV_NIBBLE_MASK};
        next_r.handler = {16'h0000, soft_trap_group_a ? ISV_CODE_TRAP_A
                                                      : ISV_CODE_TRAP_B};
        next_r.prio    = '0;
      end else if (r.nmi_pend && !(cpu_ack && r.kind == ISV_KIND_NMI)) begin
        next_r.req     = 1'b1;
        next_r.kind    = ISV_KIND_NMI;
        next_r.code    = ISV_CODE_NMI;
        next_r.handler = {16'h0000, ISV_CODE_NMI};
        next_r.prio    = '0;
      end else if (found && !(cpu_ack && r.kind == ISV_KIND_MASKABLE
                              && r.prio == win)) begin
        next_r.req     = 1'b1;
        next_r.kind    = ISV_KIND_MASKABLE;
        next_r.code    = mask_code(win);
        next_r.handler = {16'h0000, mask_code(win)};
        next_r.prio    = win;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign cpu_req       = r.req;
  assign cpu_kind      = r.kind;
  assign cpu_code      = r.code;
  assign cpu_handler   = r.handler;
  assign cpu_return_pc = r.ret_pc;
  assign cpu_prio      = r.prio;
  assign irq_pending   = r.pend;
endmodule : isv_vectoring

/* isv_vectoring_asserts.sv */
// isv_vectoring_asserts: port timing checks for isv_vectoring
// assumes: bound into isv_vectoring, one clock, sync reset
`timescale 1ns/1ps
module isv_vectoring_asserts
  import isv_pkg::*;
#(
  parameter int unsigned NUM_PINS = 7
) (
  input wire logic [NUM_PINS-1:0] ext_pin_irq,
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                lowvolt_enable,
  input wire logic                lowvolt_action_select,
  input wire logic                low_voltage_detector,
  input wire logic                timer_b_six_phase,
  input wire logic                timer_b_valley_irq,
  input wire logic                timer_b_crest_irq,
  input wire logic                soft_trap_group_a,
  input wire logic [3:0]          trap_operand,
  input wire logic                illegal_opcode_trap,
  input wire logic                debug_trap,
  input wire logic [31:0]         following_instr_address,
  input wire logic [17:0]         irq_mask,
  input wire logic                cpu_req,
  input wire isv_kind_e           cpu_kind,
  input wire logic [15:0]         cpu_code,
  input wire logic [31:0]         cpu_handler,
  input wire logic [31:0]         cpu_return_pc,
  input wire logic [4:0]          cpu_prio,
  input wire logic [17:0]         irq_pending
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [17:0] below;
  assign below = (18'h1 << cpu_prio) - 18'h1;
  sequence bad_op;
    (illegal_opcode_trap || debug_trap) && !cpu_req;
  endsequence
  sequence trap_a;
    soft_trap_group_a && !cpu_req && !illegal_opcode_trap && !debug_trap;
  endsequence
  trap_code_a: assert property (
    trap_a |=> cpu_req && cpu_handler == 32'h40
      && cpu_code == {12'h004, $past(trap_operand)})
    else $error("trap vector wrong");
  illegal_vec_a: assert property (
    bad_op |=> cpu_code == 16'h0060 && cpu_handler == 32'h60
      && cpu_return_pc == $past(following_instr_address))
    else $error("illegal opcode vector wrong");
  pin_pend_a: assert property (
    $rose(ext_pin_irq[0]) |-> ##[1:4] irq_pending[0])
    else $error("pin edge not pending");
  mask_code_a: assert property (
    cpu_req && cpu_kind == ISV_KIND_MASKABLE |-> cpu_handler ==
      {16'h0, 16'h0080 + 16'h0010 * cpu_prio
      + (cpu_prio > 5'h07 ? 16'h0020 : 16'h0000)})
    else $error("maskable code wrong");
  valley_a: assert property (
    timer_b_six_phase && timer_b_valley_irq |=> irq_pending[13])
    else $error("valley not pending");
  crest_a: assert property (
    timer_b_six_phase && timer_b_crest_irq |=> irq_pending[14])
    else $error("crest not pending");
  low_volt_a: assert property (
    lowvolt_enable && !lowvolt_action_select && $rose(low_voltage_detector)
      |-> ##[1:4] irq_pending[7])
    else $error("low voltage not pending");
  prio_min_a: assert property (
    $rose(cpu_req) && cpu_kind == ISV_KIND_MASKABLE
      |-> ($past(irq_pending) & ~$past(irq_mask) & below) == 18'h0)
    else $error("lower priority skipped");
endmodule : isv_vectoring_asserts

/* test_isv_vectoring.sv */
// test_isv_vectoring: source to vector scenarios
// assumes: isv_cpu_model answers the core side
`timescale 1ns/1ps
module test_isv_vectoring;
  import isv_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [17:0] src = 18'h0;
  logic [17:0] mask = 18'h0;
  logic [3:0]  trp = 4'h0;
  logic [3:0]  op = 4'h0;
  logic [3:0]  ack_wait = 4'h0;
  logic [1:0]  alt = 2'h0;
  logic [31:0] nxt = 32'h0;
  logic        six = 1'b0;
  logic        lv_sel = 1'b0;
  logic        wdt = 1'b0;
  logic        lv_en = 1'b1;
  logic        req, ack;
  isv_kind_e   kind;
  logic [15:0] code;
  logic [31:0] hnd, rpc;
  logic [4:0]  prio;
  logic [17:0] pend;
  int          err_total = 0;
  int          n_compared = 0;
  isv_vectoring isv_vectoring_i (.clk(clk), .rst(rst),
    .ext_pin_irq(src[6:0]), .watchdog_nmi(wdt), .lowvolt_enable(lv_en),
    .lowvolt_action_select(lv_sel), .low_voltage_detector(src[7]),
    .timer_a_overflow_irq(src[8]), .timer_a_match_irq(src[12:9]),
    .timer_b_six_phase(six), .timer_b_overflow_irq(src[13]),
    .timer_b_valley_irq(alt[0]), .timer_b_match0_irq(src[14]),
    .timer_b_crest_irq(alt[1]), .timer_b_match_irq(src[17:15]),
    .soft_trap_group_a(trp[0]), .soft_trap_group_b(trp[1]),
    .trap_operand(op), .illegal_opcode_trap(trp[2]), .debug_trap(trp[3]),
    .following_instr_address(nxt), .irq_mask(mask), .cpu_ack(ack),
    .cpu_req(req), .cpu_kind(kind), .cpu_code(code), .cpu_handler(hnd),
    .cpu_return_pc(rpc), .cpu_prio(prio), .irq_pending(pend));
  isv_cpu_model isv_cpu_model_i (.clk(clk), .rst(rst), .cpu_req(req),
    .ack_wait(ack_wait), .cpu_ack(ack));
  initial forever #4 clk = ~clk;
  function logic [15:0] mc(input int p);
    return 16'(16'h0080 + 16'h0010 * p + (p > 7 ? 16'h0020 : 16'h0000));
  endfunction : mc
  task chk(input string s, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", s, exp, got);
    end
  endtask : chk
  task pulse(input logic [17:0] v);
    src <= v;
    @(posedge clk);
    src <= 18'h0;
  endtask : pulse
  // waits for an accepted vector and judges it
  task take(input isv_kind_e k, input logic [15:0] c, input logic [31:0] h,
            input logic [4:0] p);
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (!(req && ack) && i < 60);
    chk("accepted", req && ack, 1'b1);
    chk("kind", kind, k);
    chk("code", code, c);
    chk("handler", hnd, h);
    chk("return pc", rpc, nxt);
    if (k == ISV_KIND_MASKABLE) chk("prio", prio, p);
    @(posedge clk);
  endtask : take
  task t_maskable;
    for (int p = 0; p < 18; p++) begin
      ack_wait <= 4'(p % 3 * 6);
      pulse(18'h1 << p);
      take(ISV_KIND_MASKABLE, mc(p), {16'h0, mc(p)}, 5'(p));
    end
    $display("maskable test done");
  endtask : t_maskable
  task t_six;
    six <= 1'b1;
    lv_sel <= 1'b1;
    pulse(18'h02080);
    repeat (5) @(posedge clk);
    chk("pending", pend, 18'h0);
    for (int k = 0; k < 2; k++) begin
      alt <= 2'h1 << k;
      @(posedge clk);
      alt <= 2'h0;
      take(ISV_KIND_MASKABLE, mc(13 + k), {16'h0, mc(13 + k)}, 5'(13 + k));
    end
    six <= 1'b0;
    lv_sel <= 1'b0;
    $display("six phase test done");
  endtask : t_six
  task t_prio;
    mask <= 18'h00200;
    ack_wait <= 4'hf;
    pulse(18'h09200);
    repeat (4) @(posedge clk);
    chk("masked pending", pend[9], 1'b1);
    mask <= 18'h0;
    take(ISV_KIND_MASKABLE, mc(12), {16'h0, mc(12)}, 5'h0c);
    take(ISV_KIND_MASKABLE, mc(9), {16'h0, mc(9)}, 5'h09);
    take(ISV_KIND_MASKABLE, mc(15), {16'h0, mc(15)}, 5'h0f);
    $display("priority test done");
  endtask : t_prio
  task t_trap;
    ack_wait <= 4'h1;
    for (int k = 0; k < 8; k++) begin
      op <= 4'(k * 5);
      nxt <= 32'h3a50 + k;
      trp <= 4'h1 << (k / 2);
      @(posedge clk);
      trp <= 4'h0;
      take(ISV_KIND_TRAP, k < 4 ? 16'h0040 + 16'h10 * (k / 2) + 4'(k * 5)
        : 16'h0060, k < 4 ? 32'h40 + 32'h10 * (k / 2) : 32'h60, 5'h0);
    end
    $display("trap test done");
  endtask : t_trap
  // timer overflow is vectored before the slower synchronised watchdog edge
  task t_nmi;
    ack_wait <= 4'h2;
    lv_en <= 1'b0;
    wdt <= 1'b1;
    pulse(18'h00180);
    wdt <= 1'b0;
    take(ISV_KIND_MASKABLE, mc(8), {16'h0, mc(8)}, 5'h08);
    take(ISV_KIND_NMI, 16'h0010, 32'h10, 5'h0);
    repeat (4) @(posedge clk);
    chk("lv disabled", pend[7], 1'b0);
    lv_en <= 1'b1;
    $display("nmi test done");
  endtask : t_nmi
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_maskable();
    t_six();
    t_prio();
    t_trap();
    t_nmi();
    finish_test();
  end
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule : test_isv_vectoring
bind isv_vectoring isv_vectoring_asserts #(.NUM_PINS(NUM_PINS))
  isv_vectoring_asserts_i (.*);
